/* src/tcs_consts.vh */
`ifndef TCS_CONSTS_VH
`define TCS_CONSTS_VH

// Register addresses
`define TCS_ADDR_CTRL 8'h88
`define TCS_ADDR_CLKSEL 8'h8E
`define TCS_ADDR_CFG 8'hF0

// Reset values
`define TCS_CTRL_RST 8'h00
`define TCS_CLKSEL_RST 8'h00
`define TCS_CFG_RST 8'h00
`define TCS_RDATA_UNMAPPED 8'h00

// Control register fields
`define TCS_CTRL_OV1 7
`define TCS_CTRL_RUN1 6
`define TCS_CTRL_OV0 5
`define TCS_CTRL_RUN0 4
`define TCS_CTRL_EF1 3
`define TCS_CTRL_EM1 2
`define TCS_CTRL_EF0 1
`define TCS_CTRL_EM0 0

// Clock selection fields
`define TCS_CK_T3_HI 7
`define TCS_CK_T3_LO 6
`define TCS_CK_T2_HI 5
`define TCS_CK_T2_LO 4
`define TCS_CK_T1_SYS 3
`define TCS_CK_T0_SYS 2
`define TCS_CK_PRESC_HI 1
`define TCS_CK_PRESC_LO 0

// Prescale encodings
`define TCS_PRESC_DIV12 2'h0
`define TCS_PRESC_DIV4 2'h1
`define TCS_PRESC_DIV48 2'h2
`define TCS_PRESC_EXT8 2'h3

// Configuration fields
`define TCS_CFG_T0_GATE 0
`define TCS_CFG_CT0 1
`define TCS_CFG_T1_GATE 2
`define TCS_CFG_CT1 3
`define TCS_CFG_T2_EXT 4
`define TCS_CFG_T3_EXT 5
`define TCS_CFG_POL_A 6
`define TCS_CFG_POL_B 7

// Divider terminal counts (divide ratio minus one)
`define TCS_DIV12_LAST 6'h0B
`define TCS_DIV4_LAST 6'h03
`define TCS_DIV48_LAST 6'h2F
`define TCS_EXT8_LAST 3'h7

`endif

/* src/tcs_top.v */
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`include "tcs_consts.vh"

module tcs_top (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Register port
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // External pins
    input wire ext_clk,
    input wire ext_irq_input_a,
    input wire ext_irq_input_b,
    input wire t0_pin,
    input wire t1_pin,
    // Timer datapath events and interrupt vectoring
    input wire tmr0_overflow,
    input wire tmr1_overflow,
    input wire tmr0_vec_ack,
    input wire tmr1_vec_ack,
    input wire irq0_vec_ack,
    input wire irq1_vec_ack,
    // Count enables to timer datapaths
    output reg tmr0_count_tick,
    output reg tmr1_count_tick,
    output reg t2_low_tick,
    output reg t2_high_tick,
    output reg t3_low_tick,
    output reg t3_high_tick,
    // Flags toward the interrupt controller
    output reg tmr0_overflow_flag,
    output reg tmr1_overflow_flag,
    output reg ext_irq0_flag,
    output reg ext_irq1_flag
);

    reg [7:0] timer01_control_flags;
    reg [7:0] timer_clock_selection;
    reg [7:0] irq_input_config_reg;
    reg [5:0] presc_cnt;
    reg [5:0] div12_cnt;
    reg [2:0] ext8_cnt;
    reg ext_sync1;
    reg ext_sync2;
    reg ext_prev;
    reg ext8_tick;
    reg t0_prev;
    reg t1_prev;
    reg irq_a_prev;
    reg irq_b_prev;
    reg [7:0] next_ctrl;
    reg [5:0] next_presc_cnt;
    reg presc_tick;
    wire div12_tick;
    wire irq_a_active;
    wire irq_b_active;
    wire irq_a_edge;
    wire irq_b_edge;
    wire irq0_set;
    wire irq1_set;
    wire tmr0_en;
    wire tmr1_en;
    wire tmr0_src;
    wire tmr1_src;
    wire [1:0] shared_prescale_field;

    // Byte clock for Timer 2/3: system clock or the external-select choice
    function byte_tick;
        input sysclk_sel;
        input ext_choice;
        input sys12;
        input ext8;
        begin
            if (sysclk_sel) begin
                byte_tick = 1'b1;
            end else if (ext_choice) begin
                byte_tick = ext8;
            end else begin
                byte_tick = sys12;
            end
        end
    endfunction

    // Timer 0/1 clock: counter pin, system clock or shared prescaler
    function t01_tick;
        input counter_sel;
        input sysclk_sel;
        input pin_fall;
        input presc;
        begin
            if (counter_sel) begin
                t01_tick = pin_fall;
            end else if (sysclk_sel) begin
                t01_tick = 1'b1;
            end else begin
                t01_tick = presc;
            end
        end
    endfunction

    // Flag update: software write, then vector clear, then hardware set on top
    function flag_next;
        input cur;
        input wr_en;
        input wr_val;
        input vec_clr;
        input hw_set;
        reg v;
        begin
            v = cur;
            if (wr_en) begin
                v = wr_val;
            end
            if (vec_clr) begin
                v = 1'b0;
            end
            flag_next = v | hw_set;
        end
    endfunction

    assign shared_prescale_field = timer_clock_selection[`TCS_CK_PRESC_HI:`TCS_CK_PRESC_LO];

    // Polarity bit 1 means active high; reset value gives active low
    assign irq_a_active = irq_input_config_reg[`TCS_CFG_POL_A] ? ext_irq_input_a
                                                              : ~ext_irq_input_a;
    assign irq_b_active = irq_input_config_reg[`TCS_CFG_POL_B] ? ext_irq_input_b
                                                              : ~ext_irq_input_b;
    assign irq_a_edge = irq_a_active & ~irq_a_prev;
    assign irq_b_edge = irq_b_active & ~irq_b_prev;

    assign irq0_set = timer01_control_flags[`TCS_CTRL_EM0] ? irq_a_edge : irq_a_active;
    assign irq1_set = timer01_control_flags[`TCS_CTRL_EM1] ? irq_b_edge : irq_b_active;

    assign tmr0_en = timer01_control_flags[`TCS_CTRL_RUN0]
                     & (~irq_input_config_reg[`TCS_CFG_T0_GATE] | irq_a_active);
    assign tmr1_en = timer01_control_flags[`TCS_CTRL_RUN1]
                     & (~irq_input_config_reg[`TCS_CFG_T1_GATE] | irq_b_active);

    assign tmr0_src = t01_tick(irq_input_config_reg[`TCS_CFG_CT0],
                               timer_clock_selection[`TCS_CK_T0_SYS],
                               t0_prev & ~t0_pin, presc_tick);
    assign tmr1_src = t01_tick(irq_input_config_reg[`TCS_CFG_CT1],
                               timer_clock_selection[`TCS_CK_T1_SYS],
                               t1_prev & ~t1_pin, presc_tick);

    assign div12_tick = (div12_cnt == `TCS_DIV12_LAST);

    // Shared prescaler divide ratio and tick
    always @* begin
        next_presc_cnt = presc_cnt + 6'h01;
        presc_tick = 1'b0;
        case (shared_prescale_field)
            `TCS_PRESC_DIV12: begin
                presc_tick = (presc_cnt == `TCS_DIV12_LAST);
            end
            `TCS_PRESC_DIV4: begin
                presc_tick = (presc_cnt >= `TCS_DIV4_LAST);
            end
            `TCS_PRESC_DIV48: begin
                presc_tick = (presc_cnt >= `TCS_DIV48_LAST);
            end
            `TCS_PRESC_EXT8: begin
                presc_tick = ext8_tick;
            end
            default: begin
                presc_tick = 1'b0;
            end
        endcase
        // Count from >= so a ratio change mid-period cannot leave the counter stranded
        if (shared_prescale_field != `TCS_PRESC_DIV12 && presc_tick) begin
            next_presc_cnt = 6'h00;
        end
        if (shared_prescale_field == `TCS_PRESC_DIV12 && presc_cnt >= `TCS_DIV12_LAST) begin
            next_presc_cnt = 6'h00;
        end
    end

    // Control register next value with set-wins flags
    always @* begin
        next_ctrl = timer01_control_flags;
        if (reg_wr && reg_addr == `TCS_ADDR_CTRL) begin
            next_ctrl = reg_wdata;
        end
        next_ctrl[`TCS_CTRL_OV1] = flag_next(timer01_control_flags[`TCS_CTRL_OV1],
                                             reg_wr && reg_addr == `TCS_ADDR_CTRL,
                                             reg_wdata[`TCS_CTRL_OV1], tmr1_vec_ack,
                                             tmr1_overflow);
        next_ctrl[`TCS_CTRL_OV0] = flag_next(timer01_control_flags[`TCS_CTRL_OV0],
                                             reg_wr && reg_addr == `TCS_ADDR_CTRL,
                                             reg_wdata[`TCS_CTRL_OV0], tmr0_vec_ack,
                                             tmr0_overflow);
        next_ctrl[`TCS_CTRL_EF1] = flag_next(timer01_control_flags[`TCS_CTRL_EF1],
                                             reg_wr && reg_addr == `TCS_ADDR_CTRL,
                                             reg_wdata[`TCS_CTRL_EF1],
                                             irq1_vec_ack & timer01_control_flags[`TCS_CTRL_EM1],
                                             irq1_set);
        next_ctrl[`TCS_CTRL_EF0] = flag_next(timer01_control_flags[`TCS_CTRL_EF0],
                                             reg_wr && reg_addr == `TCS_ADDR_CTRL,
                                             reg_wdata[`TCS_CTRL_EF0],
                                             irq0_vec_ack & timer01_control_flags[`TCS_CTRL_EM0],
                                             irq0_set);
    end

    // Registers and register port
    always @(posedge clk) begin
        if (srst) begin
            timer01_control_flags <= `TCS_CTRL_RST;
            timer_clock_selection <= `TCS_CLKSEL_RST;
            irq_input_config_reg <= `TCS_CFG_RST;
            reg_rdata <= `TCS_RDATA_UNMAPPED;
        end else begin
            timer01_control_flags <= next_ctrl;
            if (reg_wr && reg_addr == `TCS_ADDR_CLKSEL) begin
                timer_clock_selection <= reg_wdata;
            end
            if (reg_wr && reg_addr == `TCS_ADDR_CFG) begin
                irq_input_config_reg <= reg_wdata;
            end
            if (reg_rd) begin
                case (reg_addr)
                    `TCS_ADDR_CTRL: begin
                        reg_rdata <= timer01_control_flags;
                    end
                    `TCS_ADDR_CLKSEL: begin
                        reg_rdata <= timer_clock_selection;
                    end
                    `TCS_ADDR_CFG: begin
                        reg_rdata <= irq_input_config_reg;
                    end
                    default: begin
                        reg_rdata <= `TCS_RDATA_UNMAPPED;
                    end
                endcase
            end else begin
                reg_rdata <= `TCS_RDATA_UNMAPPED;
            end
        end
    end

    // Dividers and external clock synchronizer
    always @(posedge clk) begin
        if (srst) begin
            presc_cnt <= 6'h00;
            div12_cnt <= 6'h00;
            ext8_cnt <= 3'h0;
            ext_sync1 <= 1'b0;
            ext_sync2 <= 1'b0;
            ext_prev <= 1'b0;
            ext8_tick <= 1'b0;
        end else begin
            presc_cnt <= next_presc_cnt;
            div12_cnt <= div12_tick ? 6'h00 : div12_cnt + 6'h01;
            // Two flops before any logic sees the external clock
            ext_sync1 <= ext_clk;
            ext_sync2 <= ext_sync1;
            ext_prev <= ext_sync2;
            ext8_tick <= 1'b0;
            if (ext_sync2 && !ext_prev) begin
                ext8_cnt <= ext8_cnt + 3'h1;
                if (ext8_cnt == `TCS_EXT8_LAST) begin
                    ext8_tick <= 1'b1;
                end
            end
        end
    end

    // Pin history, count enables and flag outputs
    always @(posedge clk) begin
        if (srst) begin
            t0_prev <= 1'b0;
            t1_prev <= 1'b0;
            irq_a_prev <= 1'b0;
            irq_b_prev <= 1'b0;
            tmr0_count_tick <= 1'b0;
            tmr1_count_tick <= 1'b0;
            t2_low_tick <= 1'b0;
            t2_high_tick <= 1'b0;
            t3_low_tick <= 1'b0;
            t3_high_tick <= 1'b0;
            tmr0_overflow_flag <= 1'b0;
            tmr1_overflow_flag <= 1'b0;
            ext_irq0_flag <= 1'b0;
            ext_irq1_flag <= 1'b0;
        end else begin
            t0_prev <= t0_pin;
            t1_prev <= t1_pin;
            irq_a_prev <= irq_a_active;
            irq_b_prev <= irq_b_active;
            tmr0_count_tick <= tmr0_en & tmr0_src;
            tmr1_count_tick <= tmr1_en & tmr1_src;
            t2_low_tick <= byte_tick(timer_clock_selection[`TCS_CK_T2_LO],
                                     irq_input_config_reg[`TCS_CFG_T2_EXT],
                                     div12_tick, ext8_tick);
            // High-byte ticks only matter to the datapath in split mode
            t2_high_tick <= byte_tick(timer_clock_selection[`TCS_CK_T2_HI],
                                      irq_input_config_reg[`TCS_CFG_T2_EXT],
                                      div12_tick, ext8_tick);
            t3_low_tick <= byte_tick(timer_clock_selection[`TCS_CK_T3_LO],
                                     irq_input_config_reg[`TCS_CFG_T3_EXT],
                                     div12_tick, ext8_tick);
            t3_high_tick <= byte_tick(timer_clock_selection[`TCS_CK_T3_HI],
                                      irq_input_config_reg[`TCS_CFG_T3_EXT],
                                      div12_tick, ext8_tick);
            tmr0_overflow_flag <= next_ctrl[`TCS_CTRL_OV0];
            tmr1_overflow_flag <= next_ctrl[`TCS_CTRL_OV1];
            ext_irq0_flag <= next_ctrl[`TCS_CTRL_EF0];
            ext_irq1_flag <= next_ctrl[`TCS_CTRL_EF1];
        end
    end

endmodule // tcs_top

/* dv/tcs_top_monitor.sv */
`timescale 1ns/1ns
`include "tcs_consts.vh"
module tcs_top_monitor (
    // Clock and reset
    input logic clk,
    input logic srst,
    // Register port
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    // Events and flags
    input logic tmr0_overflow,
    input logic tmr1_overflow,
    input logic tmr0_vec_ack,
    input logic tmr1_vec_ack,
    input logic tmr0_overflow_flag,
    input logic tmr1_overflow_flag,
    input logic ext_irq0_flag,
    input logic ext_irq1_flag
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    wire wr_ctrl = reg_wr && reg_addr == `TCS_ADDR_CTRL;
    wire [3:0] flags4 = {tmr1_overflow_flag, tmr0_overflow_flag, ext_irq1_flag, ext_irq0_flag};
    sequence wr_clksel;
        reg_wr && reg_addr == `TCS_ADDR_CLKSEL;
    endsequence
    sequence rd_clksel;
        reg_rd && !reg_wr && reg_addr == `TCS_ADDR_CLKSEL;
    endsequence
    ovf0_sets_flag_a: assert property (tmr0_overflow |=> tmr0_overflow_flag)
        else $error("timer 0 overflow flag not set");
    ovf1_sets_flag_a: assert property (tmr1_overflow |=> tmr1_overflow_flag)
        else $error("timer 1 overflow flag not set");
    ack0_clears_a: assert property (tmr0_vec_ack && !tmr0_overflow && !wr_ctrl
        |=> !tmr0_overflow_flag) else $error("timer 0 flag kept after vectoring");
    ack1_clears_a: assert property (tmr1_vec_ack && !tmr1_overflow && !wr_ctrl
        |=> !tmr1_overflow_flag) else $error("timer 1 flag kept after vectoring");
    sw_clear_flag_a: assert property (wr_ctrl && !reg_wdata[5] && !tmr0_overflow
        |=> !tmr0_overflow_flag) else $error("timer 0 flag kept after write of zero");
    hw_set_wins_a: assert property (wr_ctrl && tmr1_overflow |=> tmr1_overflow_flag)
        else $error("software clear beat a hardware set");
    ctrl_read_flags_a: assert property (reg_rd && !reg_wr && reg_addr == `TCS_ADDR_CTRL
        |=> {reg_rdata[7], reg_rdata[5], reg_rdata[3], reg_rdata[1]} == $past(flags4))
        else $error("control read disagrees with flag outputs");
    clksel_readback_a: assert property (wr_clksel ##1 rd_clksel
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("clock selection readback wrong");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == `TCS_RDATA_UNMAPPED)
        else $error("read data not zero outside a read");
    reset_clears_a: assert property ($fell(srst) |-> flags4 == 4'h0)
        else $error("flags not clear after reset");
endmodule // tcs_top_monitor

bind tcs_top tcs_top_monitor tcs_top_monitor_inst (.clk(clk), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .tmr0_overflow(tmr0_overflow), .tmr1_overflow(tmr1_overflow),
    .tmr0_vec_ack(tmr0_vec_ack), .tmr1_vec_ack(tmr1_vec_ack),
    .tmr0_overflow_flag(tmr0_overflow_flag), .tmr1_overflow_flag(tmr1_overflow_flag),
    .ext_irq0_flag(ext_irq0_flag), .ext_irq1_flag(ext_irq1_flag));

/* dv/tb_tcs_top.sv */
`timescale 1ns/1ns
`include "tcs_consts.vh"
module tb_tcs_top;
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg [7:0] reg_addr = 8'h00;
    reg [7:0] reg_wdata = 8'h00;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg ext_clk = 1'b0;
    reg ext_run = 1'b0;
    reg irq_a = 1'b1;
    reg irq_b = 1'b1;
    reg t0_pin = 1'b1;
    reg t1_pin = 1'b1;
    reg [5:0] ev = 6'h00;
    wire [7:0] reg_rdata;
    wire [5:0] tk;
    wire [3:0] fl;
    integer n_fail = 0;
    integer total_checks = 0;
    integer cnt [0:5];
    integer p;
    integer k;
    tcs_top tcs_top_inst (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk(ext_clk),
        .ext_irq_input_a(irq_a), .ext_irq_input_b(irq_b), .t0_pin(t0_pin), .t1_pin(t1_pin),
        .tmr0_overflow(ev[0]), .tmr1_overflow(ev[1]), .tmr0_vec_ack(ev[2]),
        .tmr1_vec_ack(ev[3]), .irq0_vec_ack(ev[4]), .irq1_vec_ack(ev[5]),
        .tmr0_count_tick(tk[0]), .tmr1_count_tick(tk[1]), .t2_low_tick(tk[2]),
        .t2_high_tick(tk[3]), .t3_low_tick(tk[4]), .t3_high_tick(tk[5]),
        .tmr0_overflow_flag(fl[0]), .tmr1_overflow_flag(fl[1]), .ext_irq0_flag(fl[2]),
        .ext_irq1_flag(fl[3]));
    always #50 clk = ~clk;
    // External oscillator, phase unrelated to clk
    always #210 if (ext_run) ext_clk = ~ext_clk;
    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // All bus tasks are entered at a rising edge and return at one
    task wr(input [7:0] a, input [7:0] d);
        // Strobe must not be re-raised in the step that lowers it
        if (reg_wr === 1'b1) @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rdchk(input string n, input [7:0] a, input [7:0] exp);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(n, reg_rdata, exp);
        @(posedge clk);
    endtask
    task pulse(input [5:0] v);
        ev <= v;
        @(posedge clk);
        ev <= 6'h00;
    endtask
    task flag_is(input string n, input integer i, input logic exp);
        @(negedge clk);
        check(n, {7'h00, fl[i]}, {7'h00, exp});
        @(posedge clk);
    endtask
    task count_win(input integer cyc);
        for (k = 0; k < 6; k = k + 1) cnt[k] = 0;
        repeat (cyc) begin
            @(negedge clk);
            for (k = 0; k < 6; k = k + 1) cnt[k] = cnt[k] + tk[k];
        end
        @(posedge clk);
    endtask
    task t_regs;
        rdchk("ctrl reset", `TCS_ADDR_CTRL, `TCS_CTRL_RST);
        rdchk("clksel reset", `TCS_ADDR_CLKSEL, `TCS_CLKSEL_RST);
        wr(`TCS_ADDR_CLKSEL, 8'hA5);
        rdchk("clksel rw", `TCS_ADDR_CLKSEL, 8'hA5);
        wr(`TCS_ADDR_CTRL, 8'h55);
        rdchk("ctrl rw", `TCS_ADDR_CTRL, 8'h55);
        wr(8'h33, 8'hFF);
        rdchk("unmapped", 8'h33, `TCS_RDATA_UNMAPPED);
        wr(`TCS_ADDR_CTRL, 8'h00);
        $display("test regs done");
    endtask
    task t_ovf;
        pulse(6'h01);
        flag_is("ovf0 set", 0, 1'b1);
        pulse(6'h02);
        rdchk("ctrl both ovf", `TCS_ADDR_CTRL, 8'hA0);
        pulse(6'h04);
        rdchk("ovf0 acked", `TCS_ADDR_CTRL, 8'h80);
        reg_wr <= 1'b1;
        reg_addr <= `TCS_ADDR_CTRL;
        reg_wdata <= 8'h00;
        ev <= 6'h01;
        @(posedge clk);
        reg_wr <= 1'b0;
        ev <= 6'h00;
        rdchk("set beats clear", `TCS_ADDR_CTRL, 8'h20);
        wr(`TCS_ADDR_CTRL, 8'h00);
        $display("test overflow done");
    endtask
    task t_irq;
        wr(`TCS_ADDR_CTRL, 8'h05);
        irq_a <= 1'b0;
        repeat (2) @(posedge clk);
        flag_is("irq0 edge", 2, 1'b1);
        pulse(6'h10);
        repeat (3) @(posedge clk);
        flag_is("irq0 edge ack", 2, 1'b0);
        irq_a <= 1'b1;
        wr(`TCS_ADDR_CTRL, 8'h00);
        irq_b <= 1'b0;
        repeat (2) @(posedge clk);
        pulse(6'h20);
        flag_is("irq1 level ack", 3, 1'b1);
        irq_b <= 1'b1;
        wr(`TCS_ADDR_CTRL, 8'h00);
        flag_is("irq1 cleared", 3, 1'b0);
        wr(`TCS_ADDR_CFG, 8'hC0);
        repeat (2) @(posedge clk);
        flag_is("irq0 high pol", 2, 1'b1);
        wr(`TCS_ADDR_CFG, 8'h00);
        wr(`TCS_ADDR_CTRL, 8'h00);
        $display("test irq done");
    endtask
    task t_ticks;
        wr(`TCS_ADDR_CLKSEL, 8'hFC);
        wr(`TCS_ADDR_CTRL, 8'h50);
        repeat (4) @(posedge clk);
        count_win(48);
        for (p = 0; p < 6; p = p + 1) check("sysclk tick", cnt[p][7:0], 8'd48);
        wr(`TCS_ADDR_CFG, 8'h01);
        repeat (4) @(posedge clk);
        count_win(48);
        check("gated t0", cnt[0][7:0], 8'd0);
        check("ungated t1", cnt[1][7:0], 8'd48);
        wr(`TCS_ADDR_CFG, 8'h00);
        for (p = 0; p < 3; p = p + 1) begin
            wr(`TCS_ADDR_CLKSEL, p[7:0]);
            repeat (60) @(posedge clk);
            count_win(48);
            check("t0 prescale", cnt[0][7:0], (p == 0) ? 8'd4 : (p == 1) ? 8'd12 : 8'd1);
            check("t1 prescale", cnt[1][7:0], (p == 0) ? 8'd4 : (p == 1) ? 8'd12 : 8'd1);
            for (k = 2; k < 6; k = k + 1) check("byte div12", cnt[k][7:0], 8'd4);
        end
        wr(`TCS_ADDR_CFG, 8'h30);
        wr(`TCS_ADDR_CLKSEL, {6'h00, `TCS_PRESC_EXT8});
        ext_run = 1'b1;
        repeat (60) @(posedge clk);
        count_win(336);
        check("ext8 t0", (cnt[0] >= 9 && cnt[0] <= 11), 8'd1);
        check("ext8 t2", (cnt[2] >= 9 && cnt[2] <= 11), 8'd1);
        ext_run = 1'b0;
        wr(`TCS_ADDR_CFG, 8'h02);
        wr(`TCS_ADDR_CLKSEL, 8'h04);
        repeat (4) @(posedge clk);
        fork
            count_win(40);
            repeat (5) begin
                t0_pin <= 1'b0;
                repeat (3) @(posedge clk);
                t0_pin <= 1'b1;
                repeat (3) @(posedge clk);
            end
        join
        check("counter mode", cnt[0][7:0], 8'd5);
        $display("test ticks done");
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_regs;
        t_ovf;
        t_irq;
        t_ticks;
        tally_and_finish;
    end
    // About 950 cycles expected; allow ample margin
    initial begin
        #1000000;
        n_fail = n_fail + 1;
        tally_and_finish;
    end
endmodule // tb_tcs_top
